// ===== rtl/rtc_map.svh
`ifndef RTC_MAP_SVH
`define RTC_MAP_SVH
`define RADIX_50 6'd49
`define RADIX_60 6'd59
`define BCD_ZERO 4'h0
`define BCD_NINE 4'h9
`define BCD_FIVE 4'h5
`define BCD_TWO 4'h2
`define BCD_THREE 4'h3
`define BCD_ONE 4'h1
`define HZ_ZERO 6'h00
`endif

// ===== rtl/rtc_pkg.sv
package rtc_pkg;
   typedef logic [3:0] digit_t;
   typedef struct packed {
      digit_t tens;
      digit_t ones;
   } bcd_pair_t;
   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_LOAD = 2'b01,
      ST_CLEAR = 2'b10
   } mode_t;
endpackage : rtc_pkg

// ===== rtl/bcd_digit_if.sv
`timescale 1ns/1ps
interface bcd_digit_if;
   logic tick;
   logic load;
   logic clear;
   rtc_pkg::bcd_pair_t preset;
   rtc_pkg::bcd_pair_t value;
   logic carry;
   modport ctrl (output tick, output load, output clear, output preset,
      input value, input carry);
   modport cnt (input tick, input load, input clear, input preset,
      output value, output carry);
endinterface : bcd_digit_if

// ===== rtl/bcd_pair_counter.sv
`timescale 1ns/1ps
`include "rtc_map.svh"
module bcd_pair_counter #(
   parameter logic [3:0] TENS_MAX = `BCD_FIVE,
   parameter logic [3:0] ONES_MAX = `BCD_NINE,
   parameter bit WRAP_AT_TWENTY_THREE = 1'b0
) (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   bcd_digit_if.cnt port
);
   // =====================
   // wrap detection
   function automatic logic at_top(input rtc_pkg::bcd_pair_t v);
      if (WRAP_AT_TWENTY_THREE) begin
         at_top = (v.tens == `BCD_TWO) && (v.ones == `BCD_THREE);
      end else begin
         at_top = (v.tens == TENS_MAX) && (v.ones == ONES_MAX);
      end
   endfunction : at_top

   rtc_pkg::bcd_pair_t value_q;

   assign port.value = value_q;
   assign port.carry = port.tick && at_top(value_q) && !port.load && !port.clear;

   // =====================
   // counting, clear has priority over preset
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         value_q <= '0;
      end else if (port.clear) begin
         value_q <= '0;
      end else if (port.load) begin
         value_q <= port.preset;
      end else if (port.tick) begin
         if (at_top(value_q)) begin
            value_q <= '0;
         end else if (value_q.ones == `BCD_NINE) begin
            value_q.ones <= `BCD_ZERO;
            value_q.tens <= value_q.tens + `BCD_ONE;
         end else begin
            value_q.ones <= value_q.ones + `BCD_ONE;
         end
      end
   end
endmodule : bcd_pair_counter

// ===== rtl/line_frequency_bcd_time_clock.sv
`timescale 1ns/1ps
`include "rtc_map.svh"
module line_frequency_bcd_time_clock (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic line_pulse_i,
   input wire logic radix_sixty_i,
   input wire logic preset_button_n_i,
   input wire logic clear_i,
   input wire logic [7:0] preset_hour_i,
   input wire logic [7:0] preset_minute_i,
   input wire logic [7:0] preset_second_i,
   output logic [7:0] hour_o,
   output logic [7:0] minute_o,
   output logic [7:0] second_o,
   output logic [5:0] hertz_o,
   output logic second_tick_o,
   output logic minute_tick_o,
   output logic hour_tick_o,
   output logic day_tick_o
);
   // =====================
   // pin synchronisers; first stage feeds only the second
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic line_prev_q;
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= {clear_i, ~preset_button_n_i, radix_sixty_i, line_pulse_i};
         sync2_q <= sync1_q;
      end
   end

   logic line_sync;
   logic radix_sixty;
   logic button_sync;
   logic clear_sync;
   assign line_sync = sync2_q[0];
   assign radix_sixty = sync2_q[1];
   assign button_sync = sync2_q[2];
   assign clear_sync = sync2_q[3];

   // =====================
   // edge detection: one count per line cycle, one load per press
   logic button_prev_q;
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         line_prev_q <= 1'b0;
         button_prev_q <= 1'b0;
      end else begin
         line_prev_q <= line_sync;
         button_prev_q <= button_sync;
      end
   end

   logic line_rise;
   logic load_pulse;
   assign line_rise = line_sync && !line_prev_q;
   assign load_pulse = button_sync && !button_prev_q;

   // =====================
   // hertz counter
   logic [5:0] hertz_q;
   logic [5:0] hertz_top;
   logic hertz_carry;
   assign hertz_top = radix_sixty ? `RADIX_60 : `RADIX_50;
   assign hertz_carry = line_rise && (hertz_q == hertz_top) && !load_pulse && !clear_sync;

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         hertz_q <= `HZ_ZERO;
      end else if (clear_sync || load_pulse) begin
         hertz_q <= `HZ_ZERO;
      end else if (line_rise) begin
         // radix change mid-second may leave count above top; wrap catches it
         if (hertz_q >= hertz_top) begin
            hertz_q <= `HZ_ZERO;
         end else begin
            hertz_q <= hertz_q + 6'h01;
         end
      end
   end
   assign hertz_o = hertz_q;

   // =====================
   // preset switch synchronisers; reset level is one, as the pull-ups leave
   // an open switch, so a load right after reset still reads undriven bits as one
   rtc_pkg::bcd_pair_t preset_sec_s1_q;
   rtc_pkg::bcd_pair_t preset_sec_s2_q;
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         preset_sec_s1_q <= '1;
         preset_sec_s2_q <= '1;
      end else begin
         preset_sec_s1_q <= preset_second_i;
         preset_sec_s2_q <= preset_sec_s1_q;
      end
   end

   rtc_pkg::bcd_pair_t preset_min_s1_q;
   rtc_pkg::bcd_pair_t preset_min_s2_q;
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         preset_min_s1_q <= '1;
         preset_min_s2_q <= '1;
      end else begin
         preset_min_s1_q <= preset_minute_i;
         preset_min_s2_q <= preset_min_s1_q;
      end
   end

   rtc_pkg::bcd_pair_t preset_hr_s1_q;
   rtc_pkg::bcd_pair_t preset_hr_s2_q;
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         preset_hr_s1_q <= '1;
         preset_hr_s2_q <= '1;
      end else begin
         preset_hr_s1_q <= preset_hour_i;
         preset_hr_s2_q <= preset_hr_s1_q;
      end
   end

   // =====================
   // cascaded bcd counters
   bcd_digit_if sec_if ();
   bcd_digit_if min_if ();
   bcd_digit_if hr_if ();

   // preset pins are active high on the wire side of the pull-ups; a floating
   // pin arrives as one, so the loaded bit is one unless grounded
   assign sec_if.tick = hertz_carry;
   assign sec_if.load = load_pulse;
   assign sec_if.clear = clear_sync;
   assign sec_if.preset = preset_sec_s2_q;
   assign min_if.tick = sec_if.carry;
   assign min_if.load = load_pulse;
   assign min_if.clear = clear_sync;
   assign min_if.preset = preset_min_s2_q;
   assign hr_if.tick = min_if.carry;
   assign hr_if.load = load_pulse;
   assign hr_if.clear = clear_sync;
   assign hr_if.preset = preset_hr_s2_q;

   bcd_pair_counter #(
      .TENS_MAX(`BCD_FIVE),
      .ONES_MAX(`BCD_NINE),
      .WRAP_AT_TWENTY_THREE(1'b0)
   ) u_sec (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .port(sec_if.cnt)
   );
   bcd_pair_counter #(
      .TENS_MAX(`BCD_FIVE),
      .ONES_MAX(`BCD_NINE),
      .WRAP_AT_TWENTY_THREE(1'b0)
   ) u_min (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .port(min_if.cnt)
   );
   bcd_pair_counter #(
      .TENS_MAX(`BCD_TWO),
      .ONES_MAX(`BCD_THREE),
      .WRAP_AT_TWENTY_THREE(1'b1)
   ) u_hr (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .port(hr_if.cnt)
   );

   assign second_o = sec_if.value;
   assign minute_o = min_if.value;
   assign hour_o = hr_if.value;

   // =====================
   // synchronizing pulses, registered so each is one clean cycle
   logic second_tick_q;
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         second_tick_q <= 1'b0;
      end else begin
         second_tick_q <= hertz_carry;
      end
   end
   assign second_tick_o = second_tick_q;

   logic minute_tick_q;
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         minute_tick_q <= 1'b0;
      end else begin
         minute_tick_q <= sec_if.carry;
      end
   end
   assign minute_tick_o = minute_tick_q;

   logic hour_tick_q;
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         hour_tick_q <= 1'b0;
      end else begin
         hour_tick_q <= min_if.carry;
      end
   end
   assign hour_tick_o = hour_tick_q;

   logic day_tick_q;
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         day_tick_q <= 1'b0;
      end else begin
         day_tick_q <= hr_if.carry;
      end
   end
   assign day_tick_o = day_tick_q;
endmodule : line_frequency_bcd_time_clock

// ===== bench/clock_monitor.sv
`timescale 1ns/1ps
// ========
// output checks
module clock_monitor (
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   input wire logic clear_i,
   input wire logic [7:0] hour_o,
   input wire logic [7:0] minute_o,
   input wire logic [7:0] second_o,
   input wire logic [5:0] hertz_o,
   input wire logic second_tick_o,
   input wire logic hour_tick_o,
   input wire logic minute_tick_o,
   input wire logic day_tick_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   a_tick_one_cycle: assert property (second_tick_o |=> !second_tick_o)
      else $error("long second tick");
   a_second_steps: assert property (second_tick_o |-> second_o != $past(second_o, 2))
      else $error("tick without step");
   a_tick_at_wrap: assert property (second_tick_o |-> hertz_o == 6'h00)
      else $error("tick off wrap");
   a_hertz_in_range: assert property (hertz_o <= 6'h3b)
      else $error("hertz too big");
   a_minute_after_59: assert property (minute_tick_o |-> $past(second_o, 2) == 8'h59)
      else $error("bad minute tick");
   a_hour_on_zero: assert property (hour_tick_o |-> minute_o == 8'h00 && second_o == 8'h00)
      else $error("bad hour tick");
   a_day_after_23: assert property (day_tick_o |-> $past(hour_o, 2) == 8'h23)
      else $error("bad day tick");
   // sync delay is two cycles, so six leaves margin
   a_clear_holds_zero: assert property (clear_i [*6] |-> {hour_o, minute_o, second_o} == 24'h0)
      else $error("clear not zero");
endmodule : clock_monitor

// ===== bench/line_feed.sv
`timescale 1ns/1ps
// ========
// mains pulses, button and pulled-up switches
module line_feed (
   input wire logic sys_clk_i,
   output logic line_o,
   output logic button_n_o,
   output logic [23:0] preset_o
);
   logic [23:0] ground_q = 24'h000000;
   assign preset_o = ~ground_q;
   initial begin
      line_o = 1'b0;
      button_n_o = 1'b1;
   end
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge sys_clk_i) line_o <= 1'b1;
         repeat (4) @(posedge sys_clk_i);
         line_o <= 1'b0;
         repeat (4) @(posedge sys_clk_i);
      end
   endtask : pulses
   task automatic set_time(input logic [23:0] t);
      ground_q <= ~t;
      @(posedge sys_clk_i) button_n_o <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      button_n_o <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
   endtask : set_time
endmodule : line_feed

// ===== bench/line_frequency_bcd_time_clock_bench.sv
`timescale 1ns/1ps
// ========
// bench top
module line_frequency_bcd_time_clock_bench;
   logic sys_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic radix_sixty_i = 1'b0;
   logic clear_i = 1'b0;
   logic line, button_n, sec_tick, min_tick, hour_tick, day_tick;
   logic [23:0] preset;
   logic [7:0] hour, minute, second;
   logic [5:0] hertz;
   wire logic [29:0] now = {hour, minute, second, hertz};
   int failures = 0, n_compared = 0, cycles = 0, n_sec = 0, n_day = 0, n_min = 0, n_hour = 0;
   line_feed i_line_feed (.sys_clk_i, .line_o(line), .button_n_o(button_n), .preset_o(preset));
   line_frequency_bcd_time_clock i_line_frequency_bcd_time_clock (.sys_clk_i, .resetn_i,
      .line_pulse_i(line), .radix_sixty_i, .preset_button_n_i(button_n), .clear_i,
      .preset_hour_i(preset[23:16]), .preset_minute_i(preset[15:8]),
      .preset_second_i(preset[7:0]), .hour_o(hour), .minute_o(minute), .second_o(second),
      .hertz_o(hertz), .second_tick_o(sec_tick), .minute_tick_o(min_tick),
      .hour_tick_o(hour_tick),
      .day_tick_o(day_tick));
   initial forever #10 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i) begin
      cycles++;
      n_sec += sec_tick;
      n_day += day_tick;
      n_min += min_tick;
      n_hour += hour_tick;
      if (cycles == 20000) begin
         failures++;
         finish_test();
      end
   end
   task automatic check(input logic [29:0] got, input logic [29:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check
   task automatic t_radix50();
      int s0;
      s0 = n_sec;
      i_line_feed.set_time(24'h235958);
      check(now, {24'h235958, 6'h00});
      i_line_feed.pulses(49);
      check(now, {24'h235958, 6'h31});
      i_line_feed.pulses(1);
      check(now, {24'h235959, 6'h00});
      i_line_feed.pulses(50);
      check(now, 30'h0);
      check(30'(n_day), 30'h1);
      check(30'(n_sec - s0), 30'h2);
      check(30'(n_min), 30'h1);
      check(30'(n_hour), 30'h1);
      $display("done radix 50");
   endtask : t_radix50
   task automatic t_radix60();
      radix_sixty_i <= 1'b1;
      i_line_feed.set_time(24'h000059);
      i_line_feed.pulses(59);
      check(now, {24'h000059, 6'h3b});
      i_line_feed.pulses(1);
      check(now, {24'h000100, 6'h00});
      check(30'(n_min), 30'h2);
      $display("done radix 60");
   endtask : t_radix60
   task automatic t_clear();
      i_line_feed.set_time(24'hffffff);
      check(now, {24'hffffff, 6'h00});
      i_line_feed.pulses(5);
      clear_i <= 1'b1;
      i_line_feed.pulses(3);
      check(now, 30'h0);
      clear_i <= 1'b0;
      i_line_feed.pulses(2);
      check(now, {24'h000000, 6'h02});
      $display("done clear");
   endtask : t_clear
   task automatic finish_test();
      $display("compared %0d wrong %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test
   initial begin
      repeat (20) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      check(now, 30'h0);
      t_radix50();
      t_radix60();
      t_clear();
      finish_test();
   end
endmodule : line_frequency_bcd_time_clock_bench
bind line_frequency_bcd_time_clock clock_monitor i_clock_monitor (.sys_clk_i, .resetn_i,
   .clear_i, .hour_o, .minute_o, .second_o, .hertz_o, .second_tick_o, .minute_tick_o,
   .hour_tick_o, .day_tick_o);
